// ==== sdc_regs.vh ====
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// Control byte field positions
`define SDC_CTRL_ANALOG_OUTPUT_PIN_EN_BIT 6
`define SDC_CTRL_CFG_HI 5
`define SDC_CTRL_CFG_LO 4
`define SDC_CTRL_AUTO_INC_BIT 2
`define SDC_CTRL_CHAN_HI 1
`define SDC_CTRL_CHAN_LO 0

// Reset values
`define SDC_CTRL_RESET 8'h00
`define SDC_DAC_RESET 8'h00
`define SDC_RESULT_RESET 8'h80

// Fixed upper part of the bus address (arbitrary default)
`define SDC_ADDR_FIXED 4'h9

// Input configurations
`define SDC_CFG_FOUR_SINGLE 2'h0
`define SDC_CFG_TWO_DIFF 2'h3

// Highest channel numbers
`define SDC_CHAN_MAX_FOUR 2'h3
`define SDC_CHAN_MAX_THREE 2'h2
`define SDC_CHAN_MAX_TWO 2'h1

`endif

// ==== sdc_sync2.v ====
`timescale 1ns/1ps
`default_nettype none
module sdc_sync2
#(
   parameter W = 6
)
(
   // Clock, enable and reset
   input wire clk_i,
   input wire rst_b_i,
   input wire ce_i,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);

   reg [W-1:0] meta;

   // First stage is read only by the second stage
   always @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         meta <= {W{1'b1}};
         sync_o <= {W{1'b1}};
      end
      else if (ce_i)
      begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule
`default_nettype wire

// ==== sdc_serial_control.v ====
// Function
// - Answer only to fixed address part plus three pin-selected address bits.
// - Three pin-selected bits let eight such devices share one bus.
// - Second byte of a write transfer is loaded into the control register.
// - Upper nibble holds output enable and input configuration; lower nibble picks channel.
// - With auto-increment set, advance channel by one after every conversion.
// - Bit 6 enables analog output and keeps the oscillator running.
// - Nonexistent channel maps to highest channel; auto-increment then wraps to 0.
// - Reset clears control, stops converter and oscillator, floats analog output.
// - Third and later write bytes load the output data register, held until replaced.
// - Start conversion at end of read acknowledge clock, sending previous result meanwhile.
// - First byte read after reset is hexadecimal 80.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.vh"
module sdc_serial_control
#(
   parameter [3:0] ADDR_FIXED = `SDC_ADDR_FIXED
)
(
   // Clock, enable and reset
   input wire clk_i,
   input wire rst_b_i,
   input wire ce_i,
   // Serial bus pins
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   // Address select and clock source straps
   input wire addr_select_pin_0_i,
   input wire addr_select_pin_1_i,
   input wire addr_select_pin_2_i,
   input wire clock_source_select_pin_i,
   // Converter side
   input wire [7:0] adc_result_i,
   input wire adc_done_i,
   output reg adc_start_o,
   output reg [1:0] adc_channel_o,
   output reg [1:0] input_config_o,
   output reg [7:0] dac_data_o,
   output reg analog_output_pin_oe_o,
   output reg osc_run_o,
   output reg conversion_clock_pin_oe_o
);

   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_RECV = 7'h02;
   localparam [6:0] ST_RDONE = 7'h04;
   localparam [6:0] ST_ACK = 7'h08;
   localparam [6:0] ST_SEND = 7'h10;
   localparam [6:0] ST_MACK = 7'h20;
   localparam [6:0] ST_MACKH = 7'h40;

   wire [5:0] pins_sync;
   wire s_scl;
   wire s_sda;
   wire [2:0] s_addr_sel;
   wire s_ext;
   reg scl_d;
   reg sda_d;
   reg [6:0] state;
   reg [2:0] bit_cnt;
   reg [1:0] byte_idx;
   reg [7:0] shift;
   reg rw;
   reg [7:0] converter_control;
   reg [7:0] result;
   reg busy;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;

   // Highest channel that exists in a given input configuration
   function [1:0] sdc_top_chan;
      input [1:0] cfg;
      begin
         case (cfg)
            `SDC_CFG_FOUR_SINGLE: sdc_top_chan = `SDC_CHAN_MAX_FOUR;
            `SDC_CFG_TWO_DIFF: sdc_top_chan = `SDC_CHAN_MAX_TWO;
            default: sdc_top_chan = `SDC_CHAN_MAX_THREE;
         endcase
      end
   endfunction

   // Channel actually used for a requested one
   function [1:0] sdc_clamp_chan;
      input [1:0] cfg;
      input [1:0] chan;
      begin
         if (chan > sdc_top_chan(cfg))
            sdc_clamp_chan = sdc_top_chan(cfg);
         else
            sdc_clamp_chan = chan;
      end
   endfunction

   sdc_sync2 #(
      .W(6)
   ) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .async_i({clock_source_select_pin_i, addr_select_pin_2_i, addr_select_pin_1_i,
                addr_select_pin_0_i, sda_i, scl_i}),
      .sync_o(pins_sync)
   );

   assign s_scl = pins_sync[0];
   assign s_sda = pins_sync[1];
   assign s_addr_sel = pins_sync[4:2];
   assign s_ext = pins_sync[5];
   assign scl_rise = s_scl & ~scl_d;
   assign scl_fall = ~s_scl & scl_d;
   // Start and stop only count while the clock stays high across both samples
   assign start_det = s_scl & scl_d & sda_d & ~s_sda;
   assign stop_det = s_scl & scl_d & ~sda_d & s_sda;

   always @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         byte_idx <= 2'h0;
         shift <= 8'h00;
         rw <= 1'b0;
         converter_control <= `SDC_CTRL_RESET;
         dac_data_o <= `SDC_DAC_RESET;
         result <= `SDC_RESULT_RESET;
         busy <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         adc_start_o <= 1'b0;
         adc_channel_o <= 2'h0;
         input_config_o <= 2'h0;
         analog_output_pin_oe_o <= 1'b0;
         osc_run_o <= 1'b0;
         conversion_clock_pin_oe_o <= 1'b0;
      end
      else if (ce_i)
      begin
         scl_d <= s_scl;
         sda_d <= s_sda;
         sda_o <= 1'b0;
         adc_start_o <= 1'b0;
         // Oscillator idles unless the output is on or a conversion runs
         osc_run_o <= converter_control[`SDC_CTRL_ANALOG_OUTPUT_PIN_EN_BIT] | busy;
         conversion_clock_pin_oe_o <= osc_run_o & ~s_ext;
         if (adc_done_i)
         begin
            result <= adc_result_i;
            busy <= 1'b0;
            if (converter_control[`SDC_CTRL_AUTO_INC_BIT])
            begin
               // Wraps to channel 0 after the highest one
               if (adc_channel_o >= sdc_top_chan(input_config_o))
                  adc_channel_o <= 2'h0;
               else
                  adc_channel_o <= adc_channel_o + 2'h1;
            end
         end
         if (start_det)
         begin
            state <= ST_RECV;
            bit_cnt <= 3'h0;
            byte_idx <= 2'h0;
            sda_oe_o <= 1'b0;
         end
         else if (stop_det)
         begin
            state <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE: sda_oe_o <= 1'b0;
               ST_RECV:
               begin
                  if (scl_rise)
                  begin
                     shift <= {shift[6:0], s_sda};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7)
                        state <= ST_RDONE;
                  end
               end
               ST_RDONE:
               begin
                  if (scl_fall)
                  begin
                     if (byte_idx == 2'h0)
                     begin
                        if (shift[7:1] == {ADDR_FIXED, s_addr_sel})
                        begin
                           rw <= shift[0];
                           sda_oe_o <= 1'b1;
                           state <= ST_ACK;
                        end
                        else
                           state <= ST_IDLE;
                     end
                     else
                     begin
                        if (byte_idx == 2'h1)
                        begin
                           // Reserved bits are stored but steer nothing
                           converter_control <= shift;
                           input_config_o <= shift[`SDC_CTRL_CFG_HI:`SDC_CTRL_CFG_LO];
                           analog_output_pin_oe_o <= shift[`SDC_CTRL_ANALOG_OUTPUT_PIN_EN_BIT];
                           adc_channel_o <= sdc_clamp_chan(
                              shift[`SDC_CTRL_CFG_HI:`SDC_CTRL_CFG_LO],
                              shift[`SDC_CTRL_CHAN_HI:`SDC_CTRL_CHAN_LO]);
                        end
                        else
                           dac_data_o <= shift;
                        sda_oe_o <= 1'b1;
                        state <= ST_ACK;
                     end
                     if (byte_idx != 2'h2)
                        byte_idx <= byte_idx + 2'h1;
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt <= 3'h0;
                     if (rw)
                     begin
                        // Previous result goes out while the new one converts
                        shift <= result;
                        sda_oe_o <= ~result[7];
                        adc_start_o <= 1'b1;
                        busy <= 1'b1;
                        state <= ST_SEND;
                     end
                     else
                     begin
                        sda_oe_o <= 1'b0;
                        state <= ST_RECV;
                     end
                  end
               end
               ST_SEND:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt == 3'h7)
                     begin
                        sda_oe_o <= 1'b0;
                        state <= ST_MACK;
                     end
                     else
                     begin
                        shift <= {shift[6:0], 1'b0};
                        sda_oe_o <= ~shift[6];
                        bit_cnt <= bit_cnt + 3'h1;
                     end
                  end
               end
               // A not-acknowledge ends our part; line stays released
               ST_MACK:
                  if (scl_rise)
                     state <= s_sda ? ST_IDLE : ST_MACKH;
               ST_MACKH:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt <= 3'h0;
                     shift <= result;
                     sda_oe_o <= ~result[7];
                     adc_start_o <= 1'b1;
                     busy <= 1'b1;
                     state <= ST_SEND;
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ==== sdc_serial_control_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdc_serial_control_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Bus
   input wire logic scl_i,
   input wire logic sda_oe_o,
   // Converter side
   input wire logic adc_done_i,
   input wire logic adc_start_o,
   input wire logic [1:0] adc_channel_o,
   input wire logic [1:0] input_config_o,
   input wire logic [7:0] dac_data_o,
   input wire logic analog_output_pin_oe_o,
   input wire logic osc_run_o,
   input wire logic conversion_clock_pin_oe_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Synchronised bus clock has been low long enough for outputs to move
   sequence s_scl_low;
      !scl_i && !$past(scl_i, 2);
   endsequence
   sequence s_start_pulse;
      s_scl_low ##1 !adc_start_o;
   endsequence
   AST_BUS_TIMING: assert property ($changed(sda_oe_o) |-> s_scl_low)
      else $error("data line moved outside the low clock phase");
   AST_START_TIMING: assert property ($rose(adc_start_o) |-> s_start_pulse)
      else $error("conversion start not a pulse after the acknowledge clock");
   AST_DAC_HOLD: assert property ($changed(dac_data_o) |-> s_scl_low)
      else $error("output data changed outside a byte end");
   AST_CTRL_HOLD: assert property ($changed(input_config_o) |-> s_scl_low)
      else $error("configuration changed outside a byte end");
   AST_AUTO_INC: assert property (($past(adc_done_i) && $changed(adc_channel_o)) |->
      (adc_channel_o == $past(adc_channel_o) + 2'h1) || (adc_channel_o == 2'h0))
      else $error("channel did not step by one or wrap");
   AST_CLAMP: assert property ((input_config_o != 2'h0) |->
      (adc_channel_o <= ((input_config_o == 2'h3) ? 2'h1 : 2'h2)))
      else $error("channel beyond the highest of its configuration");
   AST_OSC_RUN: assert property (analog_output_pin_oe_o |=> osc_run_o)
      else $error("oscillator stopped while output enabled");
   AST_OSC_PIN: assert property ($rose(conversion_clock_pin_oe_o) |-> $past(osc_run_o))
      else $error("clock pin driven without oscillator running");
   AST_RESET: assert property (disable iff (1'b0) (ce_i && !rst_b_i) |=>
      !sda_oe_o && !analog_output_pin_oe_o && !osc_run_o && !adc_start_o
      && dac_data_o == 8'h00 && adc_channel_o == 2'h0 && input_config_o == 2'h0)
      else $error("outputs not cleared by reset");
endmodule
bind sdc_serial_control sdc_serial_control_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .ce_i(ce_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .adc_done_i(adc_done_i),
   .adc_start_o(adc_start_o), .adc_channel_o(adc_channel_o),
   .input_config_o(input_config_o), .dac_data_o(dac_data_o),
   .analog_output_pin_oe_o(analog_output_pin_oe_o), .osc_run_o(osc_run_o),
   .conversion_clock_pin_oe_o(conversion_clock_pin_oe_o));
`default_nettype wire

// ==== sdc_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdc_i2c_master (
   // Pacing clock
   input wire logic clk_i,
   // Bus lines; a released data line reads the pull-up
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Quarter of the 160 ns link period
   task automatic q();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // Data falls while clock high, then address byte follows
   task automatic start();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b0;
      q();
   endtask
   // Sample late in the high phase so a slow answer is still caught
   task automatic bit_xfer(input logic b, output logic r);
      sda_low_o = ~b;
      q();
      scl_o = 1'b1;
      q();
      q();
      r = sda_i;
      scl_o = 1'b0;
      q();
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], r);
      bit_xfer(1'b1, ack_n);
   endtask
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_xfer(1'b1, d[i]);
      bit_xfer(nack, r);
   endtask
endmodule
`default_nettype wire

// ==== tb_sdc_serial_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.vh"
module tb_sdc_serial_control;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [2:0] pins = 3'h0;
   logic clock_source_select_pin = 1'b0;
   logic adc_done = 1'b0;
   logic [7:0] adc_result = 8'h00;
   logic scl, sda_low, sda_oe, sda_out, adc_start, analog_output_pin_oe, osc_run, clk_oe;
   logic [1:0] chan, cfg, ch;
   logic [7:0] dac;
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   int starts = 0;
   wire sda = ~(sda_low | sda_oe);
   always #10 clk_i = ~clk_i;
   sdc_serial_control u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe), .addr_select_pin_0_i(pins[0]),
      .addr_select_pin_1_i(pins[1]), .addr_select_pin_2_i(pins[2]),
      .clock_source_select_pin_i(clock_source_select_pin), .adc_result_i(adc_result), .adc_done_i(adc_done),
      .adc_start_o(adc_start), .adc_channel_o(chan), .input_config_o(cfg),
      .dac_data_o(dac), .analog_output_pin_oe_o(analog_output_pin_oe), .osc_run_o(osc_run),
      .conversion_clock_pin_oe_o(clk_oe));
   sdc_i2c_master u_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   // Converter stand-in: result names the channel that was sampled
   always @(posedge clk_i)
      if (adc_start === 1'b1)
      begin
         starts++;
         ch = chan;
         repeat (4) @(posedge clk_i);
         #1;
         adc_result = {6'h30, ch};
         adc_done = 1'b1;
         @(posedge clk_i);
         #1;
         adc_done = 1'b0;
      end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic t_idle();
      chk("outs", 8'h00, {1'b0, sda_oe, analog_output_pin_oe, osc_run, clk_oe, adc_start, chan});
      chk("cfg", 8'h00, {6'h0, cfg});
      chk("dac", 8'h00, dac);
      chk("sda out", 8'h00, 8'(sda_out));
      $display("idle test done");
   endtask
   task automatic t_addr();
      logic a;
      for (int p = 0; p < 8; p++)
      begin
         pins = 3'(p);
         u_master.start();
         u_master.wr_byte({`SDC_ADDR_FIXED, pins, 1'b0}, a);
         chk("ack match", 8'h00, 8'(a));
         u_master.stop();
         u_master.start();
         u_master.wr_byte({`SDC_ADDR_FIXED, pins ^ 3'h5, 1'b0}, a);
         chk("ack other", 8'h01, 8'(a));
         u_master.wr_byte(8'h44, a);
         chk("ack after", 8'h01, 8'(a));
         u_master.stop();
      end
      chk("no write", 8'h00, {5'h0, analog_output_pin_oe, cfg});
      $display("address test done");
   endtask
   task automatic t_ctrl();
      logic a;
      logic [7:0] ctl [4] = '{8'h13, 8'h27, 8'h33, 8'h40};
      logic [4:0] exp [4] = '{5'h06, 5'h0a, 5'h0d, 5'h10};
      for (int k = 0; k < 4; k++)
      begin
         u_master.start();
         u_master.wr_byte({`SDC_ADDR_FIXED, pins, 1'b0}, a);
         u_master.wr_byte(ctl[k], a);
         u_master.wr_byte(8'h3c + 8'(k), a);
         u_master.wr_byte(8'hc3 - 8'(k), a);
         chk("byte ack", 8'h00, 8'(a));
         u_master.stop();
         chk("fields", 8'(exp[k]), {3'h0, analog_output_pin_oe, cfg, chan});
         chk("dac", 8'hc3 - 8'(k), dac);
         chk("osc", exp[k][4] ? 8'h03 : 8'h00, {6'h0, osc_run, clk_oe});
      end
      clock_source_select_pin = 1'b1;
      tick(4);
      chk("ext clock", 8'h00, 8'(clk_oe));
      clock_source_select_pin = 1'b0;
      $display("control test done");
   endtask
   task automatic t_read();
      logic a;
      logic [7:0] d;
      u_master.start();
      u_master.wr_byte({`SDC_ADDR_FIXED, pins, 1'b0}, a);
      u_master.wr_byte(8'h46, a);
      u_master.stop();
      starts = 0;
      u_master.start();
      u_master.wr_byte({`SDC_ADDR_FIXED, pins, 1'b1}, a);
      u_master.rd_byte(1'b0, d);
      chk("first read", 8'h80, d);
      u_master.rd_byte(1'b0, d);
      chk("read 2", 8'hc2, d);
      u_master.rd_byte(1'b1, d);
      chk("read 3", 8'hc3, d);
      u_master.stop();
      tick(8);
      chk("starts", 8'h03, 8'(starts));
      chk("chan wrap", 8'h01, {6'h0, chan});
      $display("read test done");
   endtask
   initial
   begin
      tick(8);
      rst_b_i = 1'b1;
      tick(4);
      t_idle();
      t_addr();
      t_ctrl();
      t_read();
      rst_b_i = 1'b0;
      tick(8);
      rst_b_i = 1'b1;
      tick(4);
      t_idle();
      report_and_stop();
   end
endmodule
`default_nettype wire
